/* fopc_cfg.svh */
`ifndef FOPC_CFG_SVH
`define FOPC_CFG_SVH
// Oscillator rate in Hz.
`define FOPC_CLK_HZ        10000000
// Side indicator blink rate in centihertz (1.25 Hz) and half period in cycles.
`define FOPC_SIDE_CHZ      125
`define FOPC_SIDE_HALF     ((`FOPC_CLK_HZ * 100) / (`FOPC_SIDE_CHZ * 2))
// Pulsed light rate in Hz and its low share in percent.
`define FOPC_PULSE_HZ      100
`define FOPC_PULSE_LOW_PCT 20
`define FOPC_PULSE_PERIOD  (`FOPC_CLK_HZ / `FOPC_PULSE_HZ)
`define FOPC_PULSE_LOW     ((`FOPC_PULSE_PERIOD * `FOPC_PULSE_LOW_PCT) / 100)
// Pin function codes for the two reassignable pins.
`define FOPC_FUNC_FAIL     2'h0
`define FOPC_FUNC_WAKE     2'h1
`define FOPC_FUNC_LOW      2'h2
`define FOPC_FUNC_HIGH     2'h3
`endif

/* fopc_host_model.sv */
`timescale 1ns/10ps
// Board around the device: alert pull-up, strap pin and the two lamp lines.
module fopc_host_model (
   // Board choices made by the bench.
   input  wire logic i_pullup_fitted,
   input  wire logic i_strap_grounded,
   input  wire logic i_side_ext,
   input  wire logic i_pulse_ext,
   // Open-drain enables from the device.
   input  wire logic i_alert_oe,
   input  wire logic i_side_oe,
   input  wire logic i_pulse_oe,
   // Resolved pin levels back to the device.
   output logic      o_alert_pin,
   output logic      o_strap_pin,
   output logic      o_side_pin,
   output logic      o_pulse_pin
);
   // A released alert line floats to the fitted pull-up, otherwise the device's own weak pull-down wins.
   assign o_alert_pin = i_alert_oe ? 1'b0 : i_pullup_fitted;
   // The strap has an internal pull-up, so only a hard ground reads low.
   assign o_strap_pin = ~i_strap_grounded;
   // Lamp lines are wired-and of the device pull-down and the outside level.
   assign o_side_pin  = i_side_oe ? 1'b0 : i_side_ext;
   assign o_pulse_pin = i_pulse_oe ? 1'b0 : i_pulse_ext;
endmodule : fopc_host_model

/* fopc_pkg.sv */
package fopc_pkg;
   // Function of a reassignable fail pin.
   typedef enum logic [1:0] {
      FOPC_FAIL = 2'h0,
      FOPC_WAKE = 2'h1,
      FOPC_LOW  = 2'h2,
      FOPC_HIGH = 2'h3
   } fopc_func_e;
   // Start-up sequencing states.
   typedef enum logic [1:0] {
      FOPC_ST_RESET  = 2'h0,
      FOPC_ST_SAMPLE = 2'h1,
      FOPC_ST_RUN    = 2'h2
   } fopc_state_e;
endpackage : fopc_pkg

/* fopc_top.sv */
`timescale 1ns/10ps
`include "fopc_cfg.svh"
// Operation
// - Alert line pulled low for wake/failure
// - Start-up alert sense selects configuration pair
// - Side indicator 1.25 Hz half duty
// - Pulsed light 100 Hz twenty percent low
// - Grounded strap at power-up enters development
// - Open strap keeps normal user mode
// - Fail pins reassignable as wake/low/high
// - Fail function is default after reset (the func inputs set the role; reset does not)
// - Reassigned pin never carries fail signalling
// - Measure select makes wake pins measurement
module fopc_top #(
   parameter int SIDE_HALF  = `FOPC_SIDE_HALF,
   parameter int PULSE_PER  = `FOPC_PULSE_PERIOD,
   parameter int PULSE_LOW  = `FOPC_PULSE_LOW
) (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // Alert events and the alert pin.
   input  wire logic       i_wake_event,
   input  wire logic       i_fail_event,
   input  wire logic       i_alert_clear,
   input  wire logic       i_alert_pin,
   output logic            o_alert_out,
   output logic            o_alert_oe,
   output logic            o_alert_pending,
   output logic            o_cfg_pullup,
   output logic            o_cfg_valid,
   // Development strap.
   input  wire logic       i_strap_pin,
   output logic            o_dev_mode,
   // Fail activation and pin function selection.
   input  wire logic       i_side_fail_on,
   input  wire logic       i_pulse_fail_on,
   input  wire logic [1:0] i_alt_pin_a_func,
   input  wire logic [1:0] i_alt_pin_b_func,
   input  wire logic       i_alt_pin_a_level,
   input  wire logic       i_alt_pin_b_level,
   // Side indicator pin, alt pin a.
   input  wire logic       i_side_indicator_pin,
   output logic            o_side_indicator_out,
   output logic            o_side_indicator_oe,
   output logic            o_alt_pin_a_high_side_switch,
   output logic            o_alt_pin_a_wake,
   // Pulsed light pin, alt pin b.
   input  wire logic       i_pulsed_light_pin,
   output logic            o_pulsed_light_out,
   output logic            o_pulsed_light_oe,
   output logic            o_alt_pin_b_high_side_switch,
   output logic            o_alt_pin_b_wake,
   // Wake input measurement routing.
   input  wire logic       i_hv_measure_select,
   input  wire logic       i_wake_in_a,
   input  wire logic       i_wake_in_b,
   output logic            o_wake_in_a_level,
   output logic            o_wake_in_b_level,
   output logic            o_meas_in_active,
   output logic            o_meas_out_enable
);
   fopc_pkg::fopc_state_e st_q;   // Start-up state.
   fopc_pkg::fopc_state_e st_d;   // Next start-up state.
   logic       alert_q;           // Alert pending, line held low.
   logic       alert_d;           // Next alert pending.
   logic       pull_q;            // Sensed pull-up.
   logic       pull_d;            // Next sensed pull-up.
   logic       dev_q;             // Development mode latch.
   logic       dev_d;             // Next development mode.
   logic [1:0] sync_alert_q;      // Alert pin synchroniser.
   logic [1:0] sync_strap_q;      // Strap synchroniser.
   logic [1:0] sync_a_q;          // Pin a synchroniser.
   logic [1:0] sync_b_q;          // Pin b synchroniser.
   logic [1:0] sync_wa_q;         // Wake a synchroniser.
   logic [1:0] sync_wb_q;         // Wake b synchroniser.
   logic       side_low_q;        // Registered side indicator drive.
   logic       side_low_d;        // Next side indicator drive.
   logic       pulse_low_w;       // Pulsed light low phase from the counter.
   logic       side_run_w;        // Side indicator wave allowed.
   logic       pulse_run_w;       // Pulsed light wave allowed.
   logic [$clog2(SIDE_HALF)-1:0] side_cnt_q;   // Half period counter.
   logic [$clog2(SIDE_HALF)-1:0] side_cnt_d;   // Next half period count.
   logic       out_a_q;           // Registered pin a drive low.
   logic       out_a_d;           // Next pin a drive low.
   logic       out_b_q;           // Registered pin b drive low.
   logic       out_b_d;           // Next pin b drive low.
   logic       hs_a_q;            // Pin a high side drive.
   logic       hs_a_d;            // Next pin a high side drive.
   logic       hs_b_q;            // Pin b high side drive.
   logic       hs_b_d;            // Next pin b high side drive.
   logic       wa_q;              // Wake a level.
   logic       wb_q;              // Wake b level.
   logic       wa_d;              // Next wake a level.
   logic       wb_d;              // Next wake b level.

   // Decodes whether a function code keeps the fail role of its pin.
   function automatic logic is_fail(input logic [1:0] f);
      is_fail = (f == `FOPC_FUNC_FAIL);
   endfunction : is_fail

   // All outside levels pass two flops; only the second stage is read.
   always_ff @(posedge i_clk) begin
      sync_alert_q <= {sync_alert_q[0], i_alert_pin};
      sync_strap_q <= {sync_strap_q[0], i_strap_pin};
      sync_a_q     <= {sync_a_q[0], i_side_indicator_pin};
      sync_b_q     <= {sync_b_q[0], i_pulsed_light_pin};
      sync_wa_q    <= {sync_wa_q[0], i_wake_in_a};
      sync_wb_q    <= {sync_wb_q[0], i_wake_in_b};
   end

   // Start-up: wait one state for the synchronisers, then sample alert and strap once.
   always_comb begin
      st_d    = st_q;
      pull_d  = pull_q;
      dev_d   = dev_q;
      alert_d = alert_q;
      case (st_q)
         fopc_pkg::FOPC_ST_RESET: begin
            st_d = fopc_pkg::FOPC_ST_SAMPLE;
         end
         fopc_pkg::FOPC_ST_SAMPLE: begin
            pull_d = sync_alert_q[1];
            dev_d  = ~sync_strap_q[1];
            st_d   = fopc_pkg::FOPC_ST_RUN;
         end
         fopc_pkg::FOPC_ST_RUN: begin
            // A new event wins over a clear in the same cycle.
            if (i_wake_event || i_fail_event) begin
               alert_d = 1'b1;
            end else if (i_alert_clear) begin
               alert_d = 1'b0;
            end
         end
         default: begin
            st_d = fopc_pkg::FOPC_ST_RESET;
         end
      endcase
   end

   // Start-up and alert registers.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_q    <= fopc_pkg::FOPC_ST_RESET;
         pull_q  <= 1'b0;
         dev_q   <= 1'b0;
         alert_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         pull_q  <= pull_d;
         dev_q   <= dev_d;
         alert_q <= alert_d;
      end
   end

   // Waves only run while fail is requested and the pin keeps its fail role.
   assign side_run_w  = i_side_fail_on && is_fail(i_alt_pin_a_func);
   assign pulse_run_w = i_pulse_fail_on && is_fail(i_alt_pin_b_func);

   // Side indicator: toggle every half period for an even square wave.
   always_comb begin
      side_cnt_d = side_cnt_q;
      side_low_d = 1'b0;
      if (side_run_w) begin
         side_low_d = side_low_q;
         if (side_cnt_q == ($clog2(SIDE_HALF))'(SIDE_HALF - 1)) begin
            side_cnt_d = '0;
            side_low_d = ~side_low_q;
         end else begin
            side_cnt_d = side_cnt_q + 1'b1;
         end
      end else begin
         side_cnt_d = '0;
      end
   end

   // Pulsed light wave comes from the counter module.
   fopc_wave #(
      .PERIOD  (PULSE_PER),
      .LOW_CYC (PULSE_LOW)
   ) u_pulse (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_enable (pulse_run_w),
      .o_low    (pulse_low_w)
   );

   // Pin drive selection per function input; reset clears the registered drives but does not set the role.
   always_comb begin
      out_a_d = 1'b0;
      hs_a_d  = 1'b0;
      out_b_d = 1'b0;
      hs_b_d  = 1'b0;
      case (i_alt_pin_a_func)
         `FOPC_FUNC_FAIL: out_a_d = side_low_d;
         `FOPC_FUNC_LOW:  out_a_d = i_alt_pin_a_level;
         `FOPC_FUNC_HIGH: hs_a_d  = i_alt_pin_a_level;
         default:         out_a_d = 1'b0;
      endcase
      case (i_alt_pin_b_func)
         `FOPC_FUNC_FAIL: out_b_d = pulse_low_w;
         `FOPC_FUNC_LOW:  out_b_d = i_alt_pin_b_level;
         `FOPC_FUNC_HIGH: hs_b_d  = i_alt_pin_b_level;
         default:         out_b_d = 1'b0;
      endcase
   end

   // Wake levels: measured pins are forced low so stale levels cannot wake anything.
   always_comb begin
      wa_d = i_hv_measure_select ? 1'b0 : sync_wa_q[1];
      wb_d = i_hv_measure_select ? 1'b0 : sync_wb_q[1];
   end

   // Pin and wave registers.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         side_cnt_q <= '0;
         side_low_q <= 1'b0;
         out_a_q    <= 1'b0;
         out_b_q    <= 1'b0;
         hs_a_q     <= 1'b0;
         hs_b_q     <= 1'b0;
         wa_q       <= 1'b0;
         wb_q       <= 1'b0;
      end else begin
         side_cnt_q <= side_cnt_d;
         side_low_q <= side_low_d;
         out_a_q    <= out_a_d;
         out_b_q    <= out_b_d;
         hs_a_q     <= hs_a_d;
         hs_b_q     <= hs_b_d;
         wa_q       <= wa_d;
         wb_q       <= wb_d;
      end
   end

   // Open-drain drives: output stays low, enable marks the pulled-low phase.
   assign o_alert_out                  = 1'b0;
   assign o_alert_oe                   = alert_q;
   assign o_alert_pending              = alert_q;
   assign o_cfg_pullup                 = pull_q;
   assign o_cfg_valid                  = (st_q == fopc_pkg::FOPC_ST_RUN);
   assign o_dev_mode                   = dev_q;
   assign o_side_indicator_out         = 1'b0;
   assign o_side_indicator_oe          = out_a_q;
   assign o_pulsed_light_out           = 1'b0;
   assign o_pulsed_light_oe            = out_b_q;
   assign o_alt_pin_a_high_side_switch = hs_a_q;
   assign o_alt_pin_b_high_side_switch = hs_b_q;
   assign o_alt_pin_a_wake             = sync_a_q[1] & (i_alt_pin_a_func == `FOPC_FUNC_WAKE);
   assign o_alt_pin_b_wake             = sync_b_q[1] & (i_alt_pin_b_func == `FOPC_FUNC_WAKE);
   assign o_wake_in_a_level            = wa_q;
   assign o_wake_in_b_level            = wb_q;
   assign o_meas_in_active             = i_hv_measure_select;
   assign o_meas_out_enable            = i_hv_measure_select;

   // An event in the run state drives the alert line low in the next cycle.
   property p_alert_set;
      @(posedge i_clk) disable iff (i_reset)
      (st_q == fopc_pkg::FOPC_ST_RUN && (i_wake_event || i_fail_event)) |=> o_alert_oe;
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("Alert not driven after event.");

   // The sampled pull-up matches the synchronised line in the sample state.
   property p_cfg_sense;
      @(posedge i_clk) disable iff (i_reset)
      (st_q == fopc_pkg::FOPC_ST_SAMPLE) |=> (o_cfg_pullup == $past(sync_alert_q[1]));
   endproperty
   a_cfg_sense: assert property (p_cfg_sense) else $error("Configuration sense wrong.");

   // Side indicator keeps its level in the cycle after the half period counter restarts.
   property p_side_toggle;
      @(posedge i_clk) disable iff (i_reset)
      (side_run_w && side_cnt_q == '0 && $past(side_run_w)) |=> (side_low_q == $past(side_low_q));
   endproperty
   a_side_toggle: assert property (p_side_toggle) else $error("Side indicator toggled early.");

   // The pulse counter leaves its low phase one cycle after the wave stops being allowed.
   // A restart in the very next cycle may legally pull low again, so only one cycle is checked.
   property p_pulse_idle;
      @(posedge i_clk) disable iff (i_reset)
      (!pulse_run_w) |=> !pulse_low_w;
   endproperty
   a_pulse_idle: assert property (p_pulse_idle) else $error("Pulsed light low while idle.");

   // Development mode follows the strap sampled at start-up.
   property p_dev_mode;
      @(posedge i_clk) disable iff (i_reset)
      (st_q == fopc_pkg::FOPC_ST_SAMPLE) |=> (o_dev_mode == !$past(sync_strap_q[1]));
   endproperty
   a_dev_mode: assert property (p_dev_mode) else $error("Development mode wrong.");

   // Pin a in the wake role never shows the fail wave.
   property p_no_fail_on_gpio;
      @(posedge i_clk) disable iff (i_reset)
      (i_alt_pin_a_func == `FOPC_FUNC_WAKE) |=> !o_side_indicator_oe;
   endproperty
   a_no_fail_on_gpio: assert property (p_no_fail_on_gpio) else $error("Fail wave on wake pin.");

   // Pin b high side drive only in the high side role.
   property p_hs_role;
      @(posedge i_clk) disable iff (i_reset)
      o_alt_pin_b_high_side_switch |-> $past(i_alt_pin_b_func) == `FOPC_FUNC_HIGH;
   endproperty
   a_hs_role: assert property (p_hs_role) else $error("High side outside its role.");

   // Measured wake pins read as low.
   property p_meas_mask;
      @(posedge i_clk) disable iff (i_reset)
      i_hv_measure_select |=> !o_wake_in_a_level && !o_wake_in_b_level;
   endproperty
   a_meas_mask: assert property (p_meas_mask) else $error("Wake level seen while measuring.");

   // Idle side indicator is released unless pin a is in the low role.
   property p_side_release;
      @(posedge i_clk) disable iff (i_reset)
      (!side_run_w) |=> !o_side_indicator_oe || $past(i_alt_pin_a_func) == `FOPC_FUNC_LOW;
   endproperty
   a_side_release: assert property (p_side_release) else $error("Side indicator held low idle.");
endmodule : fopc_top

/* fopc_top_bench.sv */
`timescale 1ns/10ps
// Self-checking bench for the fail output and pin configuration block.
module fopc_top_bench;
   localparam int SH = 8;  // Shortened side indicator half period.
   localparam int PP = 10; // Shortened pulsed light period.
   localparam int PL = 2;  // Shortened pulsed light low time.
   logic i_clk = 1'b0, i_reset = 1'b1, i_wake_event = 1'b0, i_fail_event = 1'b0, i_alert_clear = 1'b0;
   logic i_side_fail_on = 1'b0, i_pulse_fail_on = 1'b0, i_hv_measure_select = 1'b0;
   logic [1:0] i_alt_pin_a_func = 2'h0, i_alt_pin_b_func = 2'h0;
   logic i_alt_pin_a_level = 1'b0, i_alt_pin_b_level = 1'b0, i_wake_in_a = 1'b0, i_wake_in_b = 1'b0;
   logic pullup_fit = 1'b1, strap_gnd = 1'b0, side_ext = 1'b1, pulse_ext = 1'b1;
   logic alert_pin, strap_pin, side_pin, pulse_pin;
   logic o_alert_out, o_alert_oe, o_alert_pending, o_cfg_pullup, o_cfg_valid, o_dev_mode;
   logic o_side_indicator_out, o_side_indicator_oe, o_alt_pin_a_high_side_switch, o_alt_pin_a_wake;
   logic o_pulsed_light_out, o_pulsed_light_oe, o_alt_pin_b_high_side_switch, o_alt_pin_b_wake;
   logic o_wake_in_a_level, o_wake_in_b_level, o_meas_in_active, o_meas_out_enable;
   int   errors = 0; // Mismatches seen.
   int   n_checks = 0; // Comparisons made.
   logic exp_al;  // Expected alert state.
   // Clock at 10 MHz.
   always #50 i_clk = ~i_clk;
   // Device under test with short wave counts so a full period fits a few cycles.
   fopc_top #(.SIDE_HALF(SH), .PULSE_PER(PP), .PULSE_LOW(PL)) u_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_wake_event(i_wake_event), .i_fail_event(i_fail_event),
      .i_alert_clear(i_alert_clear), .i_alert_pin(alert_pin), .o_alert_out(o_alert_out),
      .o_alert_oe(o_alert_oe), .o_alert_pending(o_alert_pending), .o_cfg_pullup(o_cfg_pullup),
      .o_cfg_valid(o_cfg_valid), .i_strap_pin(strap_pin), .o_dev_mode(o_dev_mode),
      .i_side_fail_on(i_side_fail_on), .i_pulse_fail_on(i_pulse_fail_on),
      .i_alt_pin_a_func(i_alt_pin_a_func), .i_alt_pin_b_func(i_alt_pin_b_func),
      .i_alt_pin_a_level(i_alt_pin_a_level), .i_alt_pin_b_level(i_alt_pin_b_level),
      .i_side_indicator_pin(side_pin), .o_side_indicator_out(o_side_indicator_out),
      .o_side_indicator_oe(o_side_indicator_oe), .o_alt_pin_a_high_side_switch(o_alt_pin_a_high_side_switch),
      .o_alt_pin_a_wake(o_alt_pin_a_wake), .i_pulsed_light_pin(pulse_pin),
      .o_pulsed_light_out(o_pulsed_light_out), .o_pulsed_light_oe(o_pulsed_light_oe),
      .o_alt_pin_b_high_side_switch(o_alt_pin_b_high_side_switch), .o_alt_pin_b_wake(o_alt_pin_b_wake),
      .i_hv_measure_select(i_hv_measure_select), .i_wake_in_a(i_wake_in_a), .i_wake_in_b(i_wake_in_b),
      .o_wake_in_a_level(o_wake_in_a_level), .o_wake_in_b_level(o_wake_in_b_level),
      .o_meas_in_active(o_meas_in_active), .o_meas_out_enable(o_meas_out_enable)
   );
   // Board model on the far side of the pins.
   fopc_host_model u_host (
      .i_pullup_fitted(pullup_fit), .i_strap_grounded(strap_gnd), .i_side_ext(side_ext),
      .i_pulse_ext(pulse_ext), .i_alert_oe(o_alert_oe), .i_side_oe(o_side_indicator_oe),
      .i_pulse_oe(o_pulsed_light_oe), .o_alert_pin(alert_pin), .o_strap_pin(strap_pin),
      .o_side_pin(side_pin), .o_pulse_pin(pulse_pin)
   );
   // Compares a value with case equality so an unknown never passes; narrow values are zero extended.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Prints the counts and the verdict, then stops.
   task print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // Expected output of a reassigned pin: kind 0 pull-down, 1 high side, 2 wake level.
   function logic exp_pin(input int f, input logic lv, input logic ex, input int kind);
      if (kind == 0) return (f == 2) && lv;
      if (kind == 1) return (f == 3) && lv;
      return (f == 1) && ex;
   endfunction : exp_pin
   // Selects the lamp enable being measured.
   function logic cur(input logic sel);
      return sel ? o_pulsed_light_oe : o_side_indicator_oe;
   endfunction : cur
   // Resets with a chosen board and checks the start-up sampling.
   task do_reset(input logic pull, input logic gnd);
      @(posedge i_clk);
      pullup_fit <= pull;
      strap_gnd <= gnd;
      i_reset <= 1'b1;
      repeat (10) @(posedge i_clk);
      #1 check(o_alert_oe, 1'b0);
      check(o_side_indicator_oe, 1'b0);
      check(o_pulsed_light_oe, 1'b0);
      @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1 check(o_cfg_valid, 1'b1);
      check(o_cfg_pullup, pull);
      check(o_dev_mode, gnd);
   endtask : do_reset
   // Measures one low run and one released run of a lamp wave, after a fresh edge.
   task measure(input logic sel, input int lo, input int hi);
      int n;
      int t;
      n = 0;
      t = 0;
      while (cur(sel) !== 1'b0 && t < 200) begin @(posedge i_clk); #1 t++; end
      while (cur(sel) !== 1'b1 && t < 400) begin @(posedge i_clk); #1 t++; end
      while (cur(sel) === 1'b1 && n < 200) begin @(posedge i_clk); #1 n++; end
      check(n, lo);
      n = 0;
      while (cur(sel) === 1'b0 && n < 200) begin @(posedge i_clk); #1 n++; end
      check(n, hi);
   endtask : measure
   // Watchdog sized well above the expected run of about a thousand cycles.
   initial begin
      repeat (30000) @(posedge i_clk);
      errors++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      int f, k, j;
      logic w, fl, c, lv, ex, ms;
      void'($urandom(69));
      // Every board combination of pull-up and strap.
      for (k = 0; k < 4; k++) do_reset(k[0], k[1]);
      // Random alert events and clears, a raise always beating a clear.
      exp_al = 1'b0;
      for (k = 0; k < 150; k++) begin
         w = ($urandom % 4) == 0;
         fl = ($urandom % 5) == 0;
         c = ($urandom % 3) == 0;
         if (k == 7) begin w = 1'b1; c = 1'b1; end
         @(posedge i_clk);
         i_wake_event <= w;
         i_fail_event <= fl;
         i_alert_clear <= c;
         @(posedge i_clk);
         exp_al = w | fl | (exp_al & ~c);
         #1 check(o_alert_oe, exp_al);
         check(o_alert_pending, exp_al);
         check(o_alert_out, 1'b0);
      end
      @(posedge i_clk);
      i_wake_event <= 1'b0;
      i_fail_event <= 1'b0;
      i_alert_clear <= 1'b1;
      // Both waves in their default fail role, then switched off.
      i_side_fail_on <= 1'b1;
      i_pulse_fail_on <= 1'b1;
      repeat (2) measure(1'b0, SH, SH);
      repeat (2) measure(1'b1, PL, PP - PL);
      check(o_side_indicator_out, 1'b0);
      check(o_pulsed_light_out, 1'b0);
      @(posedge i_clk);
      i_side_fail_on <= 1'b0;
      i_pulse_fail_on <= 1'b0;
      repeat (2) @(posedge i_clk);
      for (j = 0; j < 20; j++) begin
         @(posedge i_clk);
         #1 check(o_side_indicator_oe | o_pulsed_light_oe, 1'b0);
      end
      // Each general role with fail still requested; the waves must not leak out.
      for (f = 1; f < 4; f++) begin
         for (k = 0; k < 3; k++) begin
            lv = $urandom % 2;
            ex = $urandom % 2;
            @(posedge i_clk);
            i_alt_pin_a_func <= f[1:0];
            i_alt_pin_b_func <= f[1:0];
            i_alt_pin_a_level <= lv;
            i_alt_pin_b_level <= ~lv;
            side_ext <= ex;
            pulse_ext <= ex;
            i_side_fail_on <= 1'b1;
            i_pulse_fail_on <= 1'b1;
            repeat (5) @(posedge i_clk);
            for (j = 0; j < 2 * SH; j++) begin
               #1 check(o_side_indicator_oe, exp_pin(f, lv, ex, 0));
               check(o_pulsed_light_oe, exp_pin(f, ~lv, ex, 0));
               check(o_alt_pin_a_high_side_switch, exp_pin(f, lv, ex, 1));
               check(o_alt_pin_b_high_side_switch, exp_pin(f, ~lv, ex, 1));
               check(o_alt_pin_a_wake, exp_pin(f, lv, ex, 2));
               check(o_alt_pin_b_wake, exp_pin(f, lv, ex, 2));
               @(posedge i_clk);
            end
         end
      end
      // Unused fail requests are turned off in the same cycle as the pins go back to their fail role.
      i_side_fail_on <= 1'b0;
      i_pulse_fail_on <= 1'b0;
      i_alt_pin_a_func <= 2'h0;
      i_alt_pin_b_func <= 2'h0;
      // Measurement routing; wake levels must read low while measuring.
      for (k = 0; k < 40; k++) begin
         ms = $urandom % 2;
         w = $urandom % 2;
         c = $urandom % 2;
         @(posedge i_clk);
         i_hv_measure_select <= ms;
         i_wake_in_a <= w;
         i_wake_in_b <= c;
         repeat (5) @(posedge i_clk);
         #1 check(o_meas_in_active, ms);
         check(o_meas_out_enable, ms);
         check(o_wake_in_a_level, w & ~ms);
         check(o_wake_in_b_level, c & ~ms);
      end
      print_verdict();
   end
endmodule : fopc_top_bench

/* fopc_wave.sv */
`timescale 1ns/10ps
`include "fopc_cfg.svh"
// Counter that runs while enabled and yields a low phase of LOW_CYC cycles in each PERIOD.
module fopc_wave #(
   parameter int PERIOD  = 1000,
   parameter int LOW_CYC = 500
) (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_reset,
   // Enable and wave output.
   input  wire logic i_enable,
   output logic      o_low
);
   localparam int W = $clog2(PERIOD);
   logic [W-1:0] cnt_q;   // Position inside the period.
   logic [W-1:0] cnt_d;   // Next position.
   logic         low_q;   // Registered low phase.
   logic         low_d;   // Next low phase.

   // The counter restarts when disabled so every burst begins with a full low phase.
   always_comb begin
      cnt_d = cnt_q;
      low_d = 1'b0;
      if (i_enable) begin
         if (cnt_q == W'(PERIOD - 1)) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
         low_d = (cnt_d < W'(LOW_CYC));
      end else begin
         cnt_d = W'(PERIOD - 1);
      end
   end

   // Registers only.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_q <= W'(PERIOD - 1);
         low_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         low_q <= low_d;
      end
   end

   assign o_low = low_q;
endmodule : fopc_wave
